// File: common/loader_defines.vh
// Constants for the pulse program loader host controller.
// Assumes inclusion by bare name from the design files.
`ifndef LOADER_DEFINES_VH
`define LOADER_DEFINES_VH
// Device I/O offsets.
`define OFS_DEVICE_RESET 3'h0
`define OFS_RUN_START 3'h1
`define OFS_WORD_BYTES 3'h2
`define OFS_TARGET_SEL 3'h3
`define OFS_ADDR_CLEAR 3'h4
`define OFS_FLAG_CLOCK 3'h5
`define OFS_DATA_BYTE 3'h6
`define OFS_LOAD_DONE 3'h7
// Target codes and word widths.
`define TARGET_FLAGS 8'hFF
`define TARGET_TUNING 8'h01
`define TARGET_PROGRAM 8'h00
`define BYTES_SHORT 8'h04
`define BYTES_INSTR 8'h0A
// Wishbone register offsets (byte addresses).
`define REG_CONTROL 4'h0
`define REG_WORD_LO 4'h4
`define REG_WORD_MID 4'h8
`define REG_WORD_HI 4'hC
// Control register commands, bits 2..0.
`define CMD_NONE 3'h0
`define CMD_START_FLAGS 3'h1
`define CMD_START_TUNING 3'h2
`define CMD_START_PROGRAM 3'h3
`define CMD_PUSH_WORD 3'h4
`define CMD_FINISH 3'h5
`define CMD_RUN 3'h6
`define CMD_STOP 3'h7
// Instruction fields.
`define INSTR_PATTERN_MSB 79
`define INSTR_DATA_MSB 55
`define INSTR_OPCODE_MSB 35
`define INSTR_DELAY_MSB 31
// Port strobe timing: cycles the write pulse is held and the gap after.
`define STROBE_NS 100
`define GAP_NS 100
`define CLK_NS 10
`define STROBE_CYCLES ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define GAP_CYCLES ((`GAP_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// File: design/wb_cmd_slave.v
// Classic Wishbone slave holding the command and data word registers.
// Assumes a single-cycle classic master; ack comes one cycle after request.
`timescale 1ns/10ps
`include "loader_defines.vh"
module wb_cmd_slave
(
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire busy,
  input wire [7:0] words_sent,
  output reg cmd_valid,
  output reg [2:0] cmd_code,
  output reg [79:0] word_out
);
  // Writes are taken in the cycle ack rises; ack drops next cycle.
  always @(posedge clk)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      cmd_valid <= 1'b0;
      cmd_code <= `CMD_NONE;
      word_out <= 80'h0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      cmd_valid <= 1'b0;
      if (wb_cyc_i & wb_stb_i & ~wb_ack_o)
      begin
        if (wb_we_i)
        begin
          // Commands arriving while busy are dropped; software polls busy.
          if (wb_adr_i == `REG_CONTROL)
          begin
            if (wb_sel_i[0] & ~busy)
            begin
              cmd_valid <= 1'b1;
              cmd_code <= wb_dat_i[2:0];
            end
          end
          else if (wb_adr_i == `REG_WORD_LO)
          begin
            if (wb_sel_i[0]) word_out[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) word_out[15:8] <= wb_dat_i[15:8];
            if (wb_sel_i[2]) word_out[23:16] <= wb_dat_i[23:16];
            if (wb_sel_i[3]) word_out[31:24] <= wb_dat_i[31:24];
          end
          else if (wb_adr_i == `REG_WORD_MID)
          begin
            if (wb_sel_i[0]) word_out[39:32] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) word_out[47:40] <= wb_dat_i[15:8];
            if (wb_sel_i[2]) word_out[55:48] <= wb_dat_i[23:16];
            if (wb_sel_i[3]) word_out[63:56] <= wb_dat_i[31:24];
          end
          else if (wb_adr_i == `REG_WORD_HI)
          begin
            if (wb_sel_i[0]) word_out[71:64] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) word_out[79:72] <= wb_dat_i[15:8];
          end
        end
        else
        begin
          // Reads: control shows state, word registers read back; else zero.
          if (wb_adr_i == `REG_CONTROL)
            wb_dat_o <= {16'h0, words_sent, 7'h0, busy};
          else if (wb_adr_i == `REG_WORD_LO)
            wb_dat_o <= word_out[31:0];
          else if (wb_adr_i == `REG_WORD_MID)
            wb_dat_o <= word_out[63:32];
          else if (wb_adr_i == `REG_WORD_HI)
            wb_dat_o <= {16'h0, word_out[79:64]};
          else
            wb_dat_o <= 32'h0;
        end
      end
    end
  end
endmodule

// File: design/port_writer.v
// Drives one byte write to the device's 3-bit I/O port.
// Assumes the device latches data on the strobe; strobe and gap are counted.
`timescale 1ns/10ps
`include "loader_defines.vh"
module port_writer
#(
  parameter STROBE_CYCLES = `STROBE_CYCLES,
  parameter GAP_CYCLES = `GAP_CYCLES
)
(
  input wire clk,
  input wire rst,
  input wire req,
  input wire [2:0] req_offset,
  input wire [7:0] req_data,
  output reg done,
  output reg [2:0] port_addr,
  output reg [7:0] port_data,
  output reg port_wr
);
  localparam IDLE = 2'h0;
  localparam STROBE = 2'h1;
  localparam GAP = 2'h2;
  reg [1:0] state_reg;
  reg [7:0] count_reg;
  // Address and data are held steady across strobe and gap for setup/hold.
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= IDLE;
      count_reg <= 8'h00;
      done <= 1'b0;
      port_addr <= 3'h0;
      port_data <= 8'h00;
      port_wr <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state_reg)
        IDLE:
        begin
          if (req)
          begin
            port_addr <= req_offset;
            port_data <= req_data;
            port_wr <= 1'b1;
            count_reg <= STROBE_CYCLES[7:0] - 8'h01;
            state_reg <= STROBE;
          end
        end
        STROBE:
        begin
          if (count_reg == 8'h00)
          begin
            port_wr <= 1'b0;
            count_reg <= GAP_CYCLES[7:0] - 8'h01;
            state_reg <= GAP;
          end
          else
            count_reg <= count_reg - 8'h01;
        end
        default:
        begin
          if (count_reg == 8'h00)
          begin
            done <= 1'b1;
            state_reg <= IDLE;
          end
          else
            count_reg <= count_reg - 8'h01;
        end
      endcase
    end
  end
endmodule

// File: design/pulse_program_loader.v
// Host controller that loads flags, tuning words and instructions into the
// pulse sequencer board over its eight-offset byte port.
// Assumes software gives orders over classic Wishbone and polls busy.
// Assumes the board latches each byte on the strobe and never answers.
// Commands are not queued; one given while busy is lost.
`timescale 1ns/10ps
`include "loader_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Software computes tuning word from frequency
// - Write zero to offset 0 resets loader
// - Offset 2 sets bytes per word
// - Offset 3 selects flags, tuning or program
// - Offset 4 clears load address counter
// - Data bytes to offset 6, MSB first
// - Offset 5 written twice after flag bytes
// - Offset 7 marks programming complete
// - Offset 1 starts the pulse program
// - Instructions are ten bytes, byte 9 first
module pulse_program_loader
#(
  parameter STROBE_CYCLES = `STROBE_CYCLES,
  parameter GAP_CYCLES = `GAP_CYCLES
)
(
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire [2:0] port_addr,
  output wire [7:0] port_data,
  output wire port_wr
);
  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer states; each step issues one port write.
  // S_IDLE waits for a software command.
  // S_SETUP sends the four writes that open a pass.
  // S_DATA sends one byte of the staged word.
  // S_SINGLE sends done, run, stop or a flag clock.
  // S_WAIT holds until the port writer is done.
  localparam S_IDLE = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_DATA = 3'h2;
  localparam S_SINGLE = 3'h3;
  localparam S_WAIT = 3'h4;

  // Sequencer state and the word in flight.
  reg [2:0] state_reg; // Current sequencer state.
  reg [2:0] return_reg; // State to resume after a port write.
  reg [1:0] setup_step_reg; // Which of the four setup writes comes next.
  reg [3:0] byte_idx_reg; // Byte of the current word still to send.
  reg [3:0] word_bytes_reg; // Bytes in a word for the active target.
  reg [7:0] target_reg; // Active load target code.
  reg [1:0] flag_clk_reg; // Remaining flag buffer clock writes.
  reg [7:0] words_sent_reg; // Words pushed since setup, mirrors device address.
  reg [79:0] shift_reg; // Word being streamed out.

  // Request lines to the port writer.
  reg req_reg; // Request to the port writer.
  reg [2:0] req_off_reg; // Offset for that request.
  reg [7:0] req_dat_reg; // Byte for that request.

  // Links to the slave and the writer.
  wire busy; // Sequencer is not idle.
  wire cmd_valid; // One-cycle command from software.
  wire [2:0] cmd_code; // Command code.
  wire [79:0] word_in; // Word staged by software.
  wire wr_done; // Port writer finished one write.

  // Busy covers the request cycle too, so no command slips in
  // between a state change and the writer taking the request.
  assign busy = (state_reg != S_IDLE) | req_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Returns the byte of a word by index; byte 9 is the top of an instruction.
  // The index never exceeds 9, so the select stays inside the word.
  // A function keeps byte order in one place.
  function [7:0] pick_byte;
    input [79:0] word;
    input [3:0] idx;
    begin
      pick_byte = word[idx * 8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register slave for software.
  // A word is staged in three bus writes, then pushed.
  wb_cmd_slave u_slave
  (
    .clk(clk),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .busy(busy),
    .words_sent(words_sent_reg),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .word_out(word_in)
  );

  // Byte port driver; its outputs are registered and go straight out.
  // Strobe and gap are parameters so a slow board is met easily.
  port_writer
  #(
    .STROBE_CYCLES(STROBE_CYCLES),
    .GAP_CYCLES(GAP_CYCLES)
  )
  u_writer
  (
    .clk(clk),
    .rst(rst),
    .req(req_reg),
    .req_offset(req_off_reg),
    .req_data(req_dat_reg),
    .done(wr_done),
    .port_addr(port_addr),
    .port_data(port_data),
    .port_wr(port_wr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequencer. Instruction fields, opcodes and tuning values are composed
  // by software the
  // controller only streams them, so any field layout passes through unchanged.
  // That covers output control, flow opcodes and delay counts alike.
  // Every write waits out the full strobe and gap; a ten-byte word
  // takes ten write cycles, traded for one simple, safe port timing.
  // The port is write-only, so nothing here confirms that the board
  // took a byte; software relies on the strobe timing.
  always @(posedge clk)
  begin
    // Reset leaves the sequencer idle with no request.
    if (rst)
    begin
      state_reg <= S_IDLE;
      return_reg <= S_IDLE;
      setup_step_reg <= 2'h0;
      byte_idx_reg <= 4'h0;
      // Width four matches flags and tuning.
      word_bytes_reg <= 4'h4;
      // Target defaults to program memory.
      target_reg <= `TARGET_PROGRAM;
      flag_clk_reg <= 2'h0;
      words_sent_reg <= 8'h00;
      shift_reg <= 80'h0;
      req_reg <= 1'b0;
      req_off_reg <= 3'h0;
      req_dat_reg <= 8'h00;
    end
    else
    begin
      // The request is a one-cycle pulse.
      req_reg <= 1'b0;
      // One state per step; S_WAIT is the default branch.
      case (state_reg)
        S_IDLE:
        begin
          // Commands are read only here.
          if (cmd_valid)
          begin
            if (cmd_code == `CMD_START_FLAGS)
            begin
              // Flag values are one four-byte word.
              target_reg <= `TARGET_FLAGS;
              word_bytes_reg <= 4'h4;
              setup_step_reg <= 2'h0;
              state_reg <= S_SETUP;
            end
            else if (cmd_code == `CMD_START_TUNING)
            begin
              // Four registers of four bytes follow, register 0 first.
              target_reg <= `TARGET_TUNING;
              word_bytes_reg <= 4'h4;
              setup_step_reg <= 2'h0;
              state_reg <= S_SETUP;
            end
            else if (cmd_code == `CMD_START_PROGRAM)
            begin
              // Instructions are ten bytes wide.
              target_reg <= `TARGET_PROGRAM;
              word_bytes_reg <= 4'hA;
              setup_step_reg <= 2'h0;
              state_reg <= S_SETUP;
            end
            else if (cmd_code == `CMD_PUSH_WORD)
            begin
              // Flag words keep all bits; only 9..0 drive TTL lines.
              // A copy lets software stage the next word.
              shift_reg <= word_in;
              byte_idx_reg <= word_bytes_reg - 4'h1;
              state_reg <= S_DATA;
            end
            else if (cmd_code == `CMD_FINISH)
            begin
              // Sent once after the last instruction.
              req_off_reg <= `OFS_LOAD_DONE;
              req_dat_reg <= 8'h00;
              state_reg <= S_SINGLE;
            end
            else if (cmd_code == `CMD_RUN)
            begin
              // Also serves as restart after a stop.
              req_off_reg <= `OFS_RUN_START;
              req_dat_reg <= 8'h00;
              state_reg <= S_SINGLE;
            end
            else if (cmd_code == `CMD_STOP)
            begin
              // Stop is the device reset write; it halts a running program.
              req_off_reg <= `OFS_DEVICE_RESET;
              req_dat_reg <= 8'h00;
              state_reg <= S_SINGLE;
            end
          end
        end

        S_SETUP:
        begin
          // Reset, width, target, address clear, in that order.
          // Every setup step is one port write.
          req_reg <= 1'b1;
          return_reg <= S_SETUP;
          state_reg <= S_WAIT;
          setup_step_reg <= setup_step_reg + 2'h1;
          // Step 0 resets, 1 sets width, 2 target, 3 clears.
          // The step count wraps to zero after the clear.
          if (setup_step_reg == 2'h0)
          begin
            req_off_reg <= `OFS_DEVICE_RESET;
            req_dat_reg <= 8'h00;
          end
          else if (setup_step_reg == 2'h1)
          begin
            req_off_reg <= `OFS_WORD_BYTES;
            req_dat_reg <= {4'h0, word_bytes_reg};
          end
          else if (setup_step_reg == 2'h2)
          begin
            req_off_reg <= `OFS_TARGET_SEL;
            req_dat_reg <= target_reg;
          end
          else
          begin
            req_off_reg <= `OFS_ADDR_CLEAR;
            req_dat_reg <= 8'h00;
            // Count restarts with the device address.
            words_sent_reg <= 8'h00;
            return_reg <= S_IDLE;
          end
        end

        S_DATA:
        begin
          // Most significant byte first down to byte 0.
          // Each byte goes to the data offset.
          req_reg <= 1'b1;
          req_off_reg <= `OFS_DATA_BYTE;
          req_dat_reg <= pick_byte(shift_reg, byte_idx_reg);
          state_reg <= S_WAIT;
          // Index zero marks the last byte of the word.
          if (byte_idx_reg == 4'h0)
          begin
            // Device address steps on a full word.
            words_sent_reg <= words_sent_reg + 8'h01;
            // Flag words go on to two buffer clock writes.
            if (target_reg == `TARGET_FLAGS)
            begin
              // Two writes: clock high, then low.
              flag_clk_reg <= 2'h2;
              return_reg <= S_SINGLE;
              req_off_reg <= `OFS_DATA_BYTE;
            end
            // Other targets are done after the last byte.
            else
              return_reg <= S_IDLE;
          end
          else
          begin
            // More bytes remain; come back for the next.
            byte_idx_reg <= byte_idx_reg - 4'h1;
            return_reg <= S_DATA;
          end
        end

        S_SINGLE:
        begin
          // Single write; for flags it repeats to raise then drop the buffer clock.
          req_reg <= 1'b1;
          state_reg <= S_WAIT;
          return_reg <= S_IDLE;
          // Otherwise offset and byte were set with the command.
          if (flag_clk_reg != 2'h0)
          begin
            req_off_reg <= `OFS_FLAG_CLOCK;
            req_dat_reg <= 8'h00;
            flag_clk_reg <= flag_clk_reg - 2'h1;
            // The first clock write comes back for the second.
            if (flag_clk_reg == 2'h2)
              return_reg <= S_SINGLE;
          end
        end

        default:
        begin
          // Wait for the port writer before the next step.
          // The done pulse lasts one cycle and is seen here.
          if (wr_done)
            state_reg <= return_reg;
        end
      endcase
    end
  end

  // No pass state survives a new setup; it starts clean.
endmodule

// File: tb/loader_chk.sv
// Checker for the loader's bus answer and device port strobes.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module loader_chk
#(
  parameter STROBE_CYCLES = 2,
  parameter GAP_CYCLES = 2
)
(
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [2:0] port_addr,
  input wire [7:0] port_data,
  input wire port_wr
);
  // Cycles the strobe has been high, and low (saturating).
  reg [7:0] hi_cnt;
  reg [7:0] lo_cnt;
  // The low count starts saturated so the first strobe needs no gap.
  always @(posedge clk)
  begin
    if (rst)
    begin
      hi_cnt <= 8'h00;
      lo_cnt <= 8'hFF;
    end
    else
    begin
      hi_cnt <= port_wr ? hi_cnt + 8'h01 : 8'h00;
      lo_cnt <= port_wr ? 8'h00 : ((lo_cnt == 8'hFF) ? lo_cnt : lo_cnt + 8'h01);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_ack_pulse;
    @(posedge clk) disable iff (rst) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_follow;
    @(posedge clk) disable iff (rst) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_follow: assert property (p_ack_follow) else $error("ack late");
  property p_hold;
    @(posedge clk) disable iff (rst) (port_wr && $past(port_wr)) |-> ($stable(port_addr) && $stable(port_data));
  endproperty
  a_hold: assert property (p_hold) else $error("port moved in strobe");
  property p_strobe_len;
    @(posedge clk) disable iff (rst) $fell(port_wr) |-> (hi_cnt == STROBE_CYCLES);
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
  property p_gap;
    @(posedge clk) disable iff (rst) $rose(port_wr) |-> (lo_cnt >= GAP_CYCLES);
  endproperty
  a_gap: assert property (p_gap) else $error("gap too short");
  property p_reset_zero;
    @(posedge clk) disable iff (rst) ($rose(port_wr) && port_addr == 3'h0) |-> port_data == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset byte not zero");
  property p_width;
    @(posedge clk) disable iff (rst) ($rose(port_wr) && port_addr == 3'h2) |-> port_data inside {8'h04, 8'h0A};
  endproperty
  a_width: assert property (p_width) else $error("bad word width");
  property p_target;
    @(posedge clk) disable iff (rst) ($rose(port_wr) && port_addr == 3'h3) |-> port_data inside {8'hFF, 8'h01, 8'h00};
  endproperty
  a_target: assert property (p_target) else $error("bad target code");
  property p_clear;
    @(posedge clk) disable iff (rst) ($rose(port_wr) && port_addr == 3'h4) |-> port_data == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("bad clear byte");
endmodule
bind pulse_program_loader loader_chk #(.STROBE_CYCLES(STROBE_CYCLES), .GAP_CYCLES(GAP_CYCLES)) loader_chk_inst
  (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .port_addr(port_addr), .port_data(port_data), .port_wr(port_wr));

// File: tb/board_model.sv
// Behavioural model of the sequencer board's eight-offset load port.
// Assumes each rising strobe is one byte write, sampled on clk.
`timescale 1ns/10ps
module board_model
(
  input wire clk,
  input wire rst,
  input wire [2:0] port_addr,
  input wire [7:0] port_data,
  input wire port_wr
);
  reg prev_wr;
  reg [7:0] width_reg;
  reg [7:0] target_reg;
  reg [3:0] addr_reg;
  reg [7:0] fill_reg;
  reg [79:0] asm_reg;
  reg [31:0] flag_pend;
  reg [31:0] flag_buf;
  reg flag_clk;
  reg [31:0] tuning [0:3];
  reg [79:0] prog [0:15];
  reg done_reg;
  reg run_reg;
  integer wr_count;
  // Bytes shift in at the bottom, so the first byte ends most significant.
  wire [79:0] next_asm = {asm_reg[71:0], port_data};
  wire [9:0] ttl_out = flag_buf[9:0];
  wire [1:0] first_sel = prog[0][79:78];
  // Only a rising strobe counts; a long strobe is still one write.
  always @(posedge clk)
  begin
    prev_wr <= port_wr;
    if (rst)
    begin
      wr_count <= 0;
      flag_clk <= 1'b0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (port_wr && !prev_wr)
    begin
      wr_count <= wr_count + 1;
      case (port_addr)
        3'h0: run_reg <= 1'b0;
        3'h1: run_reg <= 1'b1;
        3'h2: width_reg <= port_data;
        3'h3: target_reg <= port_data;
        3'h4:
        begin
          addr_reg <= 4'h0;
          fill_reg <= 8'h00;
        end
        3'h5:
        begin
          flag_clk <= !flag_clk;
          if (!flag_clk)
            flag_buf <= flag_pend;
        end
        3'h6:
        begin
          asm_reg <= next_asm;
          fill_reg <= fill_reg + 8'h01;
          if (fill_reg + 8'h01 == width_reg)
          begin
            fill_reg <= 8'h00;
            addr_reg <= addr_reg + 4'h1;
            if (target_reg == 8'hFF)
              flag_pend <= next_asm[31:0];
            else if (target_reg == 8'h01)
              tuning[addr_reg[1:0]] <= next_asm[31:0];
            else
              prog[addr_reg] <= next_asm;
          end
        end
        default: done_reg <= 1'b1;
      endcase
    end
  end
endmodule

// File: tb/pulse_program_loader_bench.sv
// Self-checking bench: software orders over Wishbone, board model behind.
// Assumes the loader header is on the include path.
`timescale 1ns/10ps
module pulse_program_loader_bench;
  reg clk;
  reg rst;
  reg wb_cyc, wb_stb, wb_we;
  reg [3:0] wb_adr;
  reg [3:0] wb_sel;
  reg [31:0] wb_dat;
  wire [31:0] wb_rdata;
  wire wb_ack;
  wire [2:0] port_addr;
  wire [7:0] port_data;
  wire port_wr;
  integer mismatches, cmp_count, cycles, i, base;
  reg [31:0] q, f;
  reg [79:0] w [0:8];
  pulse_program_loader #(.STROBE_CYCLES(2), .GAP_CYCLES(2)) pulse_program_loader_inst (.clk(clk), .rst(rst),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_rdata), .wb_ack_o(wb_ack), .port_addr(port_addr),
    .port_data(port_data), .port_wr(port_wr));
  board_model board_model_inst (.clk(clk), .rst(rst), .port_addr(port_addr), .port_data(port_data),
    .port_wr(port_wr));
  ////////////////////////////////////////////////////////////////////////////
  // Tuning word from a whole frequency in MHz at a 50 MHz board clock.
  function [31:0] tuning_word(input [7:0] mhz);
    reg [63:0] t;
    begin
      t = {56'h0, mhz} << 32;
      tuning_word = t / 64'h32;
    end
  endfunction
  // Instruction word; the delay counts from the 60 ns fixed overhead.
  function [79:0] make_instr(input [23:0] pat, input [19:0] data, input [3:0] op, input [15:0] ns);
    make_instr = {pat, data, op, 16'h0, (ns - 16'h3C) / 16'h14};
  endfunction
  task check(input string name, input [79:0] exp, input [79:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (exp !== got)
      begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // One classic cycle; the request holds until ack is sampled high.
  task wb(input we, input [3:0] a, input [31:0] d, output [31:0] r);
    begin
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      @(posedge clk);
      while (wb_ack !== 1'b1)
        @(posedge clk);
      r = wb_rdata;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
    end
  endtask
  // Issue a command, then poll busy until it clears; the bench timeout bounds it.
  task cmd(input [2:0] c);
    begin
      wb(1'b1, 4'h0, {29'h0, c}, q);
      q = 32'h1;
      while (q[0] !== 1'b0)
        wb(1'b0, 4'h0, 32'h0, q);
    end
  endtask
  task push(input [79:0] d);
    begin
      wb(1'b1, 4'h4, d[31:0], q);
      wb(1'b1, 4'h8, d[63:32], q);
      wb(1'b1, 4'hC, {16'h0, d[79:64]}, q);
      cmd(3'h4);
    end
  endtask
  task results;
    begin
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A hang counts as a mismatch and ends in the report.
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      mismatches = mismatches + 1;
      results;
    end
  end
  initial
  begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = 0;
    wb_sel = 4'hF;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(32'hA3CA));
    wb(1'b0, 4'h0, 32'h0, q);
    check("ctrl", 16'h0, q[15:0]);
    $display("test reset done");
    f = $urandom;
    base = board_model_inst.wr_count;
    cmd(3'h1);
    push({48'h0, f});
    check("flags", f, board_model_inst.flag_buf);
    check("ttl", f[9:0], board_model_inst.ttl_out);
    check("flagclk", 1'b0, board_model_inst.flag_clk);
    check("writes", 10, board_model_inst.wr_count - base);
    check("width", 8'h04, board_model_inst.width_reg);
    $display("test flags done");
    cmd(3'h2);
    for (i = 0; i < 4; i = i + 1)
    begin
      w[i] = tuning_word(8'h01 + $urandom % 24);
      push(w[i]);
    end
    for (i = 0; i < 4; i = i + 1)
      check("tuning", w[i][31:0], board_model_inst.tuning[i]);
    check("target", 8'h01, board_model_inst.target_reg);
    $display("test tuning done");
    cmd(3'h3);
    for (i = 0; i < 9; i = i + 1)
    begin
      w[i] = make_instr($urandom, $urandom, i, 16'h78 + $urandom % 1000);
      push(w[i]);
    end
    for (i = 0; i < 9; i = i + 1)
      check("instr", w[i], board_model_inst.prog[i]);
    check("sel", w[0][79:78], board_model_inst.first_sel);
    wb(1'b0, 4'h0, 32'h0, q);
    check("count", 8'h09, q[15:8]);
    check("width", 8'h0A, board_model_inst.width_reg);
    cmd(3'h5);
    check("done", 1'b1, board_model_inst.done_reg);
    cmd(3'h6);
    check("run", 1'b1, board_model_inst.run_reg);
    cmd(3'h7);
    check("stop", 1'b0, board_model_inst.run_reg);
    cmd(3'h6);
    check("restart", 1'b1, board_model_inst.run_reg);
    $display("test program done");
    base = board_model_inst.wr_count;
    wb(1'b1, 4'h0, 32'h1, q);
    cmd(3'h3);
    check("busydrop", 8'hFF, board_model_inst.target_reg);
    check("setupwr", 4, board_model_inst.wr_count - base);
    $display("test refused done");
    wb(1'b1, 4'h2, $urandom, q);
    wb(1'b0, 4'h2, 32'h0, q);
    check("unmapped", 32'h0, q);
    $display("test unmapped done");
    results;
  end
endmodule
